// ### design/mef_map.vh
`ifndef MEF_MAP_VH
`define MEF_MAP_VH

// ****************************************
// register byte offsets
// ****************************************
`define MEF_OFS_FLAGS_LO  6'h00
`define MEF_OFS_FLAGS_HI  6'h04
`define MEF_OFS_CLEAR_LO  6'h08
`define MEF_OFS_CLEAR_HI  6'h0c
`define MEF_OFS_QFLAGS    6'h10
`define MEF_OFS_QCLEAR    6'h14
`define MEF_OFS_INT_STAT  6'h18
`define MEF_OFS_INT_MASK  6'h1c

// ****************************************
// field layout
// ****************************************
`define MEF_NCH           64
`define MEF_HALF          32
`define MEF_NQ            8
`define MEF_INT_ERR_BIT   0

// ****************************************
// reset values
// ****************************************
`define MEF_RST_FLAGS     32'h0000_0000
`define MEF_RST_QFLAGS    8'h00
`define MEF_RST_INT       1'b0

`endif

// ### design/mef_flags.v
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "mef_map.vh"

module mef_flags (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [5:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg         wb_err_o,
    // dma channel events, one-cycle pulses
    input  wire [63:0] manual_trig_i,
    input  wire [63:0] chain_trig_i,
    input  wire [63:0] hw_trig_i,
    input  wire [63:0] null_entry_i,
    input  wire [63:0] serviced_i,
    // quick dma events, one-cycle pulses
    input  wire [7:0]  quick_trig_i,
    input  wire [7:0]  quick_null_i,
    input  wire [7:0]  quick_serviced_i,
    // controller error flags held elsewhere
    input  wire        ctrl_err_any_i,
    // error interrupt
    output reg         err_pulse_o,
    output reg         irq_o
);

    // ****************************************
    // state
    // ****************************************
    reg  [63:0] flags_r;
    reg  [63:0] flags_nxt;
    reg  [7:0]  qflags_r;
    reg  [7:0]  qflags_nxt;
    reg         any_err_r;
    reg         int_stat_r;
    reg         int_mask_r;

    wire [63:0] miss_man;
    wire [63:0] miss_chn;
    wire [63:0] miss_hw;
    wire [7:0]  miss_q;
    wire [63:0] chan_set;
    wire [7:0]  quick_set;
    wire        any_err_nxt;
    wire        err_evt;
    wire        int_stat_nxt;
    wire        int_mask_nxt;

    // ****************************************
    // bus decode
    // ****************************************
    wire        take;
    wire        wr;
    wire        hit;
    wire [31:0] wmask;
    reg  [31:0] rdata;

    assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign wr   = take & wb_we_i;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    wire wr_clr_lo;
    wire wr_clr_hi;
    wire wr_qclr;
    wire wr_istat;
    wire wr_imask;
    wire [31:0] wbits;

    assign wbits     = wb_dat_i & wmask;
    assign wr_clr_lo = wr & (wb_adr_i == `MEF_OFS_CLEAR_LO);
    assign wr_clr_hi = wr & (wb_adr_i == `MEF_OFS_CLEAR_HI);
    assign wr_qclr   = wr & (wb_adr_i == `MEF_OFS_QCLEAR);
    assign wr_istat  = wr & (wb_adr_i == `MEF_OFS_INT_STAT);
    assign wr_imask  = wr & (wb_adr_i == `MEF_OFS_INT_MASK);

    // ****************************************
    // missed-event detection
    // ****************************************
    // each trigger type keeps its own outstanding event;
    // one service pulse retires all three types of a channel
    mef_pend #(
        .W(`MEF_NCH)
    ) pend_man_u (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .trig_i     (manual_trig_i),
        .serviced_i (serviced_i),
        .miss_o     (miss_man)
    );

    mef_pend #(
        .W(`MEF_NCH)
    ) pend_chn_u (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .trig_i     (chain_trig_i),
        .serviced_i (serviced_i),
        .miss_o     (miss_chn)
    );

    mef_pend #(
        .W(`MEF_NCH)
    ) pend_hw_u (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .trig_i     (hw_trig_i),
        .serviced_i (serviced_i),
        .miss_o     (miss_hw)
    );

    mef_pend #(
        .W(`MEF_NQ)
    ) pend_q_u (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .trig_i     (quick_trig_i),
        .serviced_i (quick_serviced_i),
        .miss_o     (miss_q)
    );

    assign chan_set = miss_man | miss_chn | miss_hw
                    | null_entry_i;
    assign quick_set = miss_q
                     | quick_null_i;

    // ****************************************
    // sticky flags
    // ****************************************
    always @* begin
        flags_nxt = flags_r;
        if (wr_clr_lo) begin
            flags_nxt[31:0] = flags_r[31:0] & ~wbits;
        end
        if (wr_clr_hi) begin
            flags_nxt[63:32] = flags_r[63:32] & ~wbits;
        end
        flags_nxt = flags_nxt | chan_set;
    end

    always @* begin
        qflags_nxt = qflags_r;
        if (wr_qclr) begin
            qflags_nxt = qflags_r & ~wbits[7:0];
        end
        qflags_nxt = qflags_nxt | quick_set;
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            flags_r  <= {`MEF_RST_FLAGS, `MEF_RST_FLAGS};
            qflags_r <= `MEF_RST_QFLAGS;
        end else begin
            flags_r  <= flags_nxt;
            qflags_r <= qflags_nxt;
        end
    end

    // ****************************************
    // error interrupt gating
    // ****************************************
    // fires only when some flag rises out of an all-clear state
    // controller errors count as error flags for re-arming
    assign any_err_nxt = (|flags_nxt) | (|qflags_nxt) | ctrl_err_any_i;
    assign err_evt = any_err_nxt & ~any_err_r;

    // status set wins over a write-one clear in the same cycle
    assign int_stat_nxt = err_evt
                        | (int_stat_r
                           & ~(wr_istat & wbits[`MEF_INT_ERR_BIT]));
    assign int_mask_nxt = wr_imask ? wbits[`MEF_INT_ERR_BIT]
                                   : int_mask_r;

    always @(posedge clk_i) begin
        if (rst_i) begin
            any_err_r   <= 1'b0;
            err_pulse_o <= 1'b0;
            int_stat_r  <= `MEF_RST_INT;
            int_mask_r  <= `MEF_RST_INT;
            irq_o       <= 1'b0;
        end else begin
            any_err_r   <= any_err_nxt;
            err_pulse_o <= err_evt;
            int_stat_r  <= int_stat_nxt;
            int_mask_r  <= int_mask_nxt;
            irq_o       <= int_stat_nxt & int_mask_nxt;
        end
    end

    // ****************************************
    // read mux
    // ****************************************
    assign hit = (wb_adr_i == `MEF_OFS_FLAGS_LO)
               | (wb_adr_i == `MEF_OFS_FLAGS_HI)
               | (wb_adr_i == `MEF_OFS_CLEAR_LO)
               | (wb_adr_i == `MEF_OFS_CLEAR_HI)
               | (wb_adr_i == `MEF_OFS_QFLAGS)
               | (wb_adr_i == `MEF_OFS_QCLEAR)
               | (wb_adr_i == `MEF_OFS_INT_STAT)
               | (wb_adr_i == `MEF_OFS_INT_MASK);

    always @* begin
        case (wb_adr_i)
            `MEF_OFS_FLAGS_LO: begin
                rdata = flags_r[31:0];
            end
            `MEF_OFS_FLAGS_HI: begin
                rdata = flags_r[63:32];
            end
            `MEF_OFS_QFLAGS: begin
                rdata = {24'h000000, qflags_r};
            end
            `MEF_OFS_INT_STAT: begin
                rdata = {31'h00000000, int_stat_r};
            end
            `MEF_OFS_INT_MASK: begin
                rdata = {31'h00000000, int_mask_r};
            end
            default: begin
                rdata = 32'h0000_0000;
            end
        endcase
    end

    // ****************************************
    // bus answer
    // ****************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= take & hit;
            wb_err_o <= take & ~hit;
            if (take & ~wb_we_i & hit) begin
                wb_dat_o <= rdata;
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

endmodule // mef_flags

// ****************************************
// outstanding-event tracker
// ****************************************
module mef_pend #(
    parameter W = 64
) (
    // clock and reset
    input  wire         clk_i,
    input  wire         rst_i,
    // events, one-cycle pulses
    input  wire [W-1:0] trig_i,
    input  wire [W-1:0] serviced_i,
    // second event while one is outstanding
    output wire [W-1:0] miss_o
);

    // ****************************************
    // pending events
    // ****************************************
    reg [W-1:0] pend_r;

    // a trigger in the cycle of its service is not a miss
    assign miss_o = trig_i & pend_r & ~serviced_i;

    always @(posedge clk_i) begin
        if (rst_i) begin
            pend_r <= {W{1'b0}};
        end else begin
            pend_r <= (pend_r & ~serviced_i) | trig_i;
        end
    end

endmodule // mef_pend

`default_nettype wire

// ### bench/mef_flags_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mef_flags_assertions (
    input wire logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i,
    input wire logic [5:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o, wb_err_o, err_pulse_o, ctrl_err_any_i,
    input wire logic [63:0] hw_trig_i, manual_trig_i, chain_trig_i,
    input wire logic [63:0] null_entry_i,
    input wire logic [7:0]  quick_trig_i, quick_null_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire tk = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wire ev = |{hw_trig_i, manual_trig_i, chain_trig_i, null_entry_i,
                quick_trig_i, quick_null_i};
    chk_bus_answer: assert property (tk |=> wb_ack_o ^ wb_err_o)
        else $error("no single answer");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    chk_err_unmapped: assert property (tk && wb_adr_i[5] |=> wb_err_o)
        else $error("unmapped not refused");
    chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("data outside ack");
    chk_clear_reads: assert property (tk && !wb_we_i &&
        wb_adr_i inside {6'h08, 6'h0c, 6'h14} |=> wb_dat_o == 32'h0)
        else $error("clear reg read not zero");
    chk_quick_resv: assert property (tk && !wb_we_i &&
        wb_adr_i == 6'h10 |=> wb_dat_o[31:8] == 24'h0)
        else $error("quick reserved bits set");
    chk_pulse_once: assert property (err_pulse_o |=> !err_pulse_o)
        else $error("pulse too long");
    chk_pulse_cause: assert property (err_pulse_o |->
        $past(ev) || $past(ctrl_err_any_i))
        else $error("pulse without event");
    chk_no_rearm: assert property ($past(ctrl_err_any_i, 2) &&
        !$past(rst_i, 2) |-> !err_pulse_o)
        else $error("pulse while error held");
    cover property (err_pulse_o);
    cover property (wb_err_o);
    cover property (wb_ack_o && wb_dat_o != 32'h0);
endmodule // mef_flags_assertions
bind mef_flags mef_flags_assertions mef_flags_assertions_i (.*);
`default_nettype wire

// ### bench/mef_flags_test.sv
`timescale 1ns/1ps
`default_nettype none
module mef_flags_test;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, cerr = 0;
    logic [5:0]  adr = 6'h0;
    logic [3:0]  sel = 4'hf, s;
    logic [31:0] dat = 32'h0, rdat, q, d, m;
    logic        ack, err, pls, irq, e, st, msk, z;
    logic [63:0] man = '0, chn = '0, hw = '0, nul = '0, srv = '0, mf, pend [3];
    logic [7:0]  qt = '0, qn = '0, qs = '0, mq, qp;
    int          error_cnt = 0, checked = 0, cyc_n = 0, np = 0;
    always #50 clk_i = ~clk_i;
    mef_flags mef_flags_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
        .manual_trig_i(man), .chain_trig_i(chn), .hw_trig_i(hw),
        .null_entry_i(nul), .serviced_i(srv), .quick_trig_i(qt),
        .quick_null_i(qn), .quick_serviced_i(qs), .ctrl_err_any_i(cerr),
        .err_pulse_o(pls), .irq_o(irq));
    task chk(input logic [31:0] g, x);
        checked++;
        if (g !== x) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    task final_report;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one classic cycle; answer taken and request dropped at the ack or err edge
    task wb(input logic w, input logic [5:0] a, input logic [31:0] dd,
            input logic [3:0] ss);
        @(posedge clk_i);
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, dd, ss};
        do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
        q = rdat;
        e = err;
        {cyc, stb} <= 2'b00;
    endtask
    task pulse(input int k, c);
        z = mf == 0 && mq == 0 && !cerr;
        @(posedge clk_i);
        case (k)
            0: man[c] <= 1'b1;
            1: chn[c] <= 1'b1;
            2: hw[c] <= 1'b1;
            3: nul[c] <= 1'b1;
            4: srv[c] <= 1'b1;
            5: qt[c%8] <= 1'b1;
            6: qn[c%8] <= 1'b1;
            default: qs[c%8] <= 1'b1;
        endcase
        if (k < 3) begin
            mf[c] |= pend[k][c];
            pend[k][c] = 1'b1;
        end
        if (k == 3) mf[c] = 1'b1;
        if (k == 4) for (int i = 0; i < 3; i++) pend[i][c] = 1'b0;
        if (k == 5) begin
            mq[c%8] |= qp[c%8];
            qp[c%8] = 1'b1;
        end
        if (k == 6) mq[c%8] = 1'b1;
        if (k == 7) qp[c%8] = 1'b0;
        if (z && (mf != 0 || mq != 0)) st = 1'b1;
        @(posedge clk_i);
        {man, chn, hw, nul, srv, qt, qn, qs} <= '0;
    endtask
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (pls === 1'b1) np++;
        if (cyc_n == 5000) begin
            error_cnt++;
            final_report;
        end
    end
    initial begin
        {mf, mq, qp, st} = '0;
        for (int i = 0; i < 3; i++) pend[i] = '0;
        void'($urandom(28));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 36; a += 4) begin
            wb(1'b0, a[5:0], 32'h0, 4'hf);
            chk({31'h0, e}, {31'h0, a == 32});
            chk(q, 32'h0);
        end
        $display("reset test done");
        for (int r = 0; r < 6; r++) begin
            cerr <= r == 3;
            msk = $urandom_range(1) == 1;
            wb(1'b1, 6'h1c, {31'h0, msk}, 4'hf);
            wb(1'b1, 6'h18, 32'h1, 4'hf);
            st = 1'b0;
            np = 0;
            repeat (30) pulse($urandom_range(7), $urandom_range(63));
            wb(1'b0, 6'h00, 32'h0, 4'hf);
            chk(q, mf[31:0]);
            wb(1'b0, 6'h04, 32'h0, 4'hf);
            chk(q, mf[63:32]);
            wb(1'b0, 6'h10, 32'h0, 4'hf);
            chk(q, {24'h0, mq});
            chk({31'h0, irq}, {31'h0, st & msk});
            chk(np, {31'h0, st});
            for (int j = 0; j < 3; j++) begin
                d = r[0] ? 32'hffff_ffff : $urandom;
                s = r[0] ? 4'hf : 4'($urandom);
                wb(1'b1, j == 2 ? 6'h14 : 6'(8 + 4 * j), d, s);
                m = d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
                if (j == 0) mf[31:0] &= ~m;
                if (j == 1) mf[63:32] &= ~m;
                if (j == 2) mq &= ~m[7:0];
            end
            $display("round %0d done", r);
        end
        // a set landing with a clear on the same flag must win
        for (int j = 0; j < 2; j++) begin
            fork
                wb(1'b1, j ? 6'h14 : 6'h08, 32'hffff_ffff, 4'hf);
                begin
                    @(posedge clk_i);
                    if (j == 1) qn[2] <= 1'b1;
                    else nul[3] <= 1'b1;
                    @(posedge clk_i);
                    {nul, qn} <= '0;
                end
            join
        end
        mf[31:0] = 32'h0000_0008;
        mq = 8'h04;
        wb(1'b0, 6'h00, 32'h0, 4'hf);
        chk(q, mf[31:0]);
        wb(1'b0, 6'h10, 32'h0, 4'hf);
        chk(q, {24'h0, mq});
        $display("collision test done");
        // reset in mid-run wipes flags, status and mask
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        {mf, mq, qp} = '0;
        for (int i = 0; i < 3; i++) pend[i] = '0;
        for (int a = 0; a < 32; a += 4) begin
            wb(1'b0, a[5:0], 32'h0, 4'hf);
            chk(q, 32'h0);
        end
        chk({31'h0, irq}, 32'h0);
        $display("mid-run reset test done");
        final_report;
    end
endmodule // mef_flags_test
`default_nettype wire
